/* pmc_mode_control.sv */
// Mode control bank of the performance monitor: control registers and counter gating
`timescale 1ns/10ps
// Functional notes
// - Bit 16 of first control enables interrupt when counter one goes negative.
// - Bit 17 enables interrupt for other counters; overrides freeze-on-exception.
// - Bit 18 holds counters two to eight until counter one negative or interrupt.
// - First control bits 19 to 25 select counter one event.
// - First control bits 26 to 31 select counter two event.
// - Second control is a 32-bit register at special register 798.
// - Second control reads and writes only in supervisor mode.
// - Second control is all zeros after reset.
// - Reading second control changes none of its fields.
// - Second control bits 0-4, 5-9, 10-14 select counters three to five.
// - Bits 15-19, 20-24 and four-bit 25-28 select counters six to eight.
// - Bit 29 set stops all counter updates until a monitored breakpoint match.
// - Bit 30 puts counter one in history mode.
// - Bit 31 puts counters two to eight in history mode.
// - All counters count their selected events concurrently.
// - A counter is negative when its top bit is set.
// - Interrupt needs both counter enable and global enable set.
// - Freeze-on-exception stops all counters after an interrupt until software clears.
module pmc_mode_control
  import pmc_pkg::*;
#(
  parameter int unsigned COUNTERS = pmc_pkg::NUM_COUNTERS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Special register access
  input wire logic spr_wr,
  input wire logic spr_rd,
  input wire logic [9:0] spr_num,
  input wire logic [pmc_pkg::WORD_W-1:0] spr_wdata,
  output logic [pmc_pkg::WORD_W-1:0] spr_rdata,
  output logic spr_priv_fault,
  // Machine state
  input wire logic problem_state_bit,
  input wire logic monitor_mark_bit,
  // Breakpoint and counter state
  input wire logic instr_address_breakpoint,
  input wire logic [COUNTERS-1:0] counter_sign,
  // Gating and selections to the counters
  output logic [COUNTERS-1:0] counter_update_en,
  output logic [COUNTERS-1:0] counter_history_mode,
  output logic [pmc_pkg::SEL1_W-1:0] counter_one_event_select,
  output logic [pmc_pkg::SEL2_W-1:0] counter_two_event_select,
  output logic [pmc_pkg::SEL_MID_W-1:0] counter_three_event_select,
  output logic [pmc_pkg::SEL_MID_W-1:0] counter_four_event_select,
  output logic [pmc_pkg::SEL_MID_W-1:0] counter_five_event_select,
  output logic [pmc_pkg::SEL_MID_W-1:0] counter_six_event_select,
  output logic [pmc_pkg::SEL_MID_W-1:0] counter_seven_event_select,
  output logic [pmc_pkg::SEL8_W-1:0] counter_eight_event_select,
  // Interrupt signal to the exception logic
  output logic monitor_irq
);
  import pmc_pkg::*;

  initial begin
    if (COUNTERS != NUM_COUNTERS) begin
      $error("pmc_mode_control supports exactly eight counters");
    end
  end

  logic [WORD_W-1:0] monitor_control_first;
  logic [WORD_W-1:0] monitor_control_second;
  logic frozen_by_exc;
  logic trigger_seen;
  logic supervisor;
  logic hit_first;
  logic hit_second;
  logic allowed;
  logic monitored_match;
  logic irq_cond;
  logic exc_freeze_active;
  logic hold_others;

  assign supervisor = ~problem_state_bit;
  assign hit_first = (spr_num == SPR_CTRL_FIRST);
  assign hit_second = (spr_num == SPR_CTRL_SECOND);

  // Counting allowed by the low freeze bits and the machine state
  assign allowed = ~monitor_control_first[B_FREEZE_ALL]
      & ~(monitor_control_first[B_FREEZE_SUP] & supervisor)
      & ~(monitor_control_first[B_FREEZE_USR] & problem_state_bit)
      & ~(monitor_control_first[B_FREEZE_MARK1] & monitor_mark_bit)
      & ~(monitor_control_first[B_FREEZE_MARK0] & ~monitor_mark_bit);
  assign monitored_match = instr_address_breakpoint & allowed;

  // Counter negative is its top bit; interrupt needs both enables
  assign irq_cond = monitor_control_first[B_GLOBAL_XE]
      & ((monitor_control_first[B_FIRST_XE] & counter_sign[0])
      | (monitor_control_first[B_OTHER_XE] & (|counter_sign[COUNTERS-1:1])));
  assign monitor_irq = irq_cond;

  // First control: software writes; hardware drops the global enable on interrupt
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      monitor_control_first <= CTRL_RESET;
    end else if (spr_wr && hit_first) begin
      monitor_control_first <= spr_wdata;
    end else if (irq_cond) begin
      monitor_control_first[B_GLOBAL_XE] <= 1'b0;
    end
  end

  // Second control: supervisor-only; a hardware clear of bit 29 loses to nothing but reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      monitor_control_second <= CTRL_RESET;
    end else if (spr_wr && hit_second && supervisor) begin
      monitor_control_second <= spr_wdata;
      if (monitored_match) begin
        monitor_control_second[B_FREEZE_BKPT] <= 1'b0;
      end
    end else if (monitored_match) begin
      monitor_control_second[B_FREEZE_BKPT] <= 1'b0;
    end
  end

  // Freeze after interrupt, held until software rewrites the first control
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      frozen_by_exc <= 1'b0;
    end else if (irq_cond && monitor_control_first[B_FREEZE_EXC]) begin
      frozen_by_exc <= 1'b1;
    end else if (spr_wr && hit_first) begin
      frozen_by_exc <= 1'b0;
    end
  end

  // Trigger release: counter one negative or interrupt, rearmed by a write
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      trigger_seen <= 1'b0;
    end else if (counter_sign[0] || irq_cond) begin
      trigger_seen <= 1'b1;
    end else if (spr_wr && hit_first) begin
      trigger_seen <= 1'b0;
    end
  end

  // Other-counter exception enable overrides freeze-on-exception
  assign exc_freeze_active = frozen_by_exc & ~monitor_control_first[B_OTHER_XE];
  assign hold_others = monitor_control_first[B_TRIGGER] & ~trigger_seen & ~counter_sign[0];

  // Counters update concurrently, each under the shared gates
  genvar gi;
  generate
    for (gi = 0; gi < COUNTERS; gi++) begin : g_gate
      if (gi == 0) begin : g_first
        assign counter_update_en[gi] = allowed & ~exc_freeze_active
            & ~monitor_control_second[B_FREEZE_BKPT];
        assign counter_history_mode[gi] = monitor_control_second[B_HIST_FIRST];
      end else begin : g_other
        assign counter_update_en[gi] = allowed & ~exc_freeze_active & ~hold_others
            & ~monitor_control_second[B_FREEZE_BKPT];
        assign counter_history_mode[gi] = monitor_control_second[B_HIST_OTHER];
      end
    end
  endgenerate

  // Event selectors straight from the register fields
  assign counter_one_event_select = monitor_control_first[F_SEL1_LO +: SEL1_W];
  assign counter_two_event_select = monitor_control_first[F_SEL2_LO +: SEL2_W];
  assign counter_three_event_select = monitor_control_second[F_SEL3_LO +: SEL_MID_W];
  assign counter_four_event_select = monitor_control_second[F_SEL4_LO +: SEL_MID_W];
  assign counter_five_event_select = monitor_control_second[F_SEL5_LO +: SEL_MID_W];
  assign counter_six_event_select = monitor_control_second[F_SEL6_LO +: SEL_MID_W];
  assign counter_seven_event_select = monitor_control_second[F_SEL7_LO +: SEL_MID_W];
  assign counter_eight_event_select = monitor_control_second[F_SEL8_LO +: SEL8_W];

  // Read data registered; reads never touch state
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      spr_rdata <= CTRL_RESET;
      spr_priv_fault <= 1'b0;
    end else begin
      spr_priv_fault <= (spr_rd || spr_wr) && hit_second && !supervisor;
      if (spr_rd && hit_first) begin
        spr_rdata <= monitor_control_first;
      end else if (spr_rd && hit_second && supervisor) begin
        spr_rdata <= monitor_control_second;
      end else begin
        spr_rdata <= CTRL_RESET;
      end
    end
  end

  // Privilege checks on the second control register
  a_user_write_blocked: assert property (@(posedge sys_clk) disable iff (!nrst)
    (spr_wr && hit_second && problem_state_bit && !monitored_match)
    |=> $stable(monitor_control_second))
    else $error("user write changed second control");

  a_fault_pulse: assert property (@(posedge sys_clk) disable iff (!nrst)
    ((spr_wr || spr_rd) && hit_second && problem_state_bit)
    |=> spr_priv_fault)
    else $error("user access to second control raised no fault");

  a_fault_only_user: assert property (@(posedge sys_clk) disable iff (!nrst)
    spr_priv_fault |-> $past(problem_state_bit))
    else $error("fault raised in supervisor mode");

  a_fault_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
    !(spr_rd || spr_wr) |=> !spr_priv_fault)
    else $error("fault raised without an access");

  a_user_read_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
    (spr_rd && hit_second && problem_state_bit)
    |=> (spr_rdata == '0))
    else $error("user read returned second control");

  // Reads hand back the word and leave it alone
  a_read_no_effect: assert property (@(posedge sys_clk) disable iff (!nrst)
    (spr_rd && !spr_wr && !monitored_match) |=> $stable(monitor_control_second))
    else $error("read changed second control");

  a_sup_read_data: assert property (@(posedge sys_clk) disable iff (!nrst)
    (spr_rd && hit_second && supervisor)
    |=> (spr_rdata == $past(monitor_control_second)))
    else $error("supervisor read returned wrong data");

  a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
    !spr_rd |=> (spr_rdata == '0))
    else $error("read data stood without a read");

  a_unmapped_read_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
    (spr_rd && !hit_first && !hit_second) |=> (spr_rdata == '0))
    else $error("unmapped read returned data");

  // Writes land whole, one cycle after the strobe
  a_sup_write_lands: assert property (@(posedge sys_clk) disable iff (!nrst)
    (spr_wr && hit_second && supervisor && !monitored_match)
    |=> (monitor_control_second == $past(spr_wdata)))
    else $error("supervisor write to second control lost");

  a_first_write_lands: assert property (@(posedge sys_clk) disable iff (!nrst)
    (spr_wr && hit_first) |=> (monitor_control_first == $past(spr_wdata)))
    else $error("write to first control lost");

  a_sel_one: assert property (@(posedge sys_clk) disable iff (!nrst)
    (spr_wr && hit_first)
    |=> (counter_one_event_select == $past(spr_wdata[F_SEL1_LO +: SEL1_W])))
    else $error("counter one selector wrong");

  a_sel_two: assert property (@(posedge sys_clk) disable iff (!nrst)
    (spr_wr && hit_first)
    |=> (counter_two_event_select == $past(spr_wdata[F_SEL2_LO +: SEL2_W])))
    else $error("counter two selector wrong");

  a_sel_three: assert property (@(posedge sys_clk) disable iff (!nrst)
    (spr_wr && hit_second && supervisor)
    |=> (counter_three_event_select == $past(spr_wdata[F_SEL3_LO +: SEL_MID_W])))
    else $error("counter three selector wrong");

  a_sel_four: assert property (@(posedge sys_clk) disable iff (!nrst)
    (spr_wr && hit_second && supervisor)
    |=> (counter_four_event_select == $past(spr_wdata[F_SEL4_LO +: SEL_MID_W])))
    else $error("counter four selector wrong");

  a_sel_five: assert property (@(posedge sys_clk) disable iff (!nrst)
    (spr_wr && hit_second && supervisor)
    |=> (counter_five_event_select == $past(spr_wdata[F_SEL5_LO +: SEL_MID_W])))
    else $error("counter five selector wrong");

  a_sel_six: assert property (@(posedge sys_clk) disable iff (!nrst)
    (spr_wr && hit_second && supervisor)
    |=> (counter_six_event_select == $past(spr_wdata[F_SEL6_LO +: SEL_MID_W])))
    else $error("counter six selector wrong");

  a_sel_seven: assert property (@(posedge sys_clk) disable iff (!nrst)
    (spr_wr && hit_second && supervisor)
    |=> (counter_seven_event_select == $past(spr_wdata[F_SEL7_LO +: SEL_MID_W])))
    else $error("counter seven selector wrong");

  a_sel_eight: assert property (@(posedge sys_clk) disable iff (!nrst)
    (spr_wr && hit_second && supervisor)
    |=> (counter_eight_event_select == $past(spr_wdata[F_SEL8_LO +: SEL8_W])))
    else $error("counter eight selector wrong");

  // History mode selects
  a_hist_first: assert property (@(posedge sys_clk) disable iff (!nrst)
    (spr_wr && hit_second && supervisor)
    |=> (counter_history_mode[0] == $past(spr_wdata[B_HIST_FIRST])))
    else $error("counter one history mode wrong");

  a_history_map: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(monitor_control_second[B_HIST_OTHER]) |-> (&counter_history_mode[COUNTERS-1:1]))
    else $error("history mode not applied");

  a_history_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    !monitor_control_second[B_HIST_OTHER] |-> (counter_history_mode[COUNTERS-1:1] == '0))
    else $error("history mode stuck on");

  // Breakpoint freeze
  a_freeze_set_by_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    (spr_wr && hit_second && supervisor && spr_wdata[B_FREEZE_BKPT] && !monitored_match)
    |=> monitor_control_second[B_FREEZE_BKPT])
    else $error("freeze bit not taken from write");

  a_bkpt_freeze_gates: assert property (@(posedge sys_clk) disable iff (!nrst)
    monitor_control_second[B_FREEZE_BKPT] |-> (counter_update_en == '0))
    else $error("counters enabled while frozen for breakpoint");

  a_match_clears_freeze: assert property (@(posedge sys_clk) disable iff (!nrst)
    monitored_match |=> !monitor_control_second[B_FREEZE_BKPT])
    else $error("freeze bit survived monitored match");

  a_unmonitored_match: assert property (@(posedge sys_clk) disable iff (!nrst)
    (instr_address_breakpoint && !allowed && monitor_control_second[B_FREEZE_BKPT]
      && !(spr_wr && hit_second))
    |=> monitor_control_second[B_FREEZE_BKPT])
    else $error("unmonitored match cleared freeze bit");

  // Freeze bits and machine state gate every counter
  a_gate_allowed: assert property (@(posedge sys_clk) disable iff (!nrst)
    !allowed |-> (counter_update_en == '0))
    else $error("counters enabled while freeze bits forbid");

  a_freeze_all: assert property (@(posedge sys_clk) disable iff (!nrst)
    monitor_control_first[B_FREEZE_ALL] |-> !allowed)
    else $error("freeze-all bit ignored");

  a_freeze_user: assert property (@(posedge sys_clk) disable iff (!nrst)
    (monitor_control_first[B_FREEZE_USR] && problem_state_bit) |-> !allowed)
    else $error("user freeze ignored");

  a_freeze_sup: assert property (@(posedge sys_clk) disable iff (!nrst)
    (monitor_control_first[B_FREEZE_SUP] && supervisor) |-> !allowed)
    else $error("supervisor freeze ignored");

  a_freeze_mark: assert property (@(posedge sys_clk) disable iff (!nrst)
    ((monitor_control_first[B_FREEZE_MARK1] && monitor_mark_bit)
      || (monitor_control_first[B_FREEZE_MARK0] && !monitor_mark_bit)) |-> !allowed)
    else $error("mark freeze ignored");

  a_concurrent_run: assert property (@(posedge sys_clk) disable iff (!nrst)
    (allowed && !exc_freeze_active && !hold_others && !monitor_control_second[B_FREEZE_BKPT])
    |-> (&counter_update_en))
    else $error("counters not running together");

  // Trigger gate
  a_trigger_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    hold_others |-> (counter_update_en[COUNTERS-1:1] == '0))
    else $error("other counters ran while trigger held");

  a_trigger_release: assert property (@(posedge sys_clk) disable iff (!nrst)
    counter_sign[0] |-> !hold_others)
    else $error("trigger held after counter one negative");

  a_first_not_held: assert property (@(posedge sys_clk) disable iff (!nrst)
    (hold_others && allowed && !exc_freeze_active && !monitor_control_second[B_FREEZE_BKPT])
    |-> counter_update_en[0])
    else $error("trigger held counter one");

  // Interrupt signalling and the freeze that follows it
  a_irq_needs_enables: assert property (@(posedge sys_clk) disable iff (!nrst)
    monitor_irq |-> monitor_control_first[B_GLOBAL_XE]
      && (monitor_control_first[B_FIRST_XE] || monitor_control_first[B_OTHER_XE]))
    else $error("interrupt without enables");

  a_no_irq_without_global: assert property (@(posedge sys_clk) disable iff (!nrst)
    !monitor_control_first[B_GLOBAL_XE] |-> !monitor_irq)
    else $error("interrupt with global enable clear");

  a_neg_first_irq: assert property (@(posedge sys_clk) disable iff (!nrst)
    (counter_sign[0] && monitor_control_first[B_FIRST_XE] && monitor_control_first[B_GLOBAL_XE]
      && !(spr_wr && hit_first))
    |-> monitor_irq ##1 !monitor_control_first[B_GLOBAL_XE])
    else $error("counter one negative did not signal");

  a_neg_other_irq: assert property (@(posedge sys_clk) disable iff (!nrst)
    (counter_sign[1] && monitor_control_first[B_OTHER_XE] && monitor_control_first[B_GLOBAL_XE])
    |-> monitor_irq)
    else $error("other counter negative did not signal");

  a_exc_freeze_holds: assert property (@(posedge sys_clk) disable iff (!nrst)
    (irq_cond && monitor_control_first[B_FREEZE_EXC] && !spr_wr
      && !monitor_control_first[B_OTHER_XE])
    |=> (counter_update_en == '0) [*2] or (spr_wr && hit_first))
    else $error("counters ran after freezing interrupt");

  a_freeze_sticks: assert property (@(posedge sys_clk) disable iff (!nrst)
    (frozen_by_exc && !(spr_wr && hit_first)) |=> frozen_by_exc)
    else $error("exception freeze released without a write");

  a_exc_freeze_gates: assert property (@(posedge sys_clk) disable iff (!nrst)
    exc_freeze_active |-> (counter_update_en == '0))
    else $error("counters enabled while exception freeze active");

  // The other-counter enable keeps counters running through an exception freeze
  a_override_freeze: assert property (@(posedge sys_clk) disable iff (!nrst)
    (monitor_control_first[B_OTHER_XE] && allowed && !hold_others
      && !monitor_control_second[B_FREEZE_BKPT])
    |-> (&counter_update_en))
    else $error("override of exception freeze ignored");
endmodule

/* pmc_mode_control_bench.sv */
// Self-checking bench for the performance monitor mode control bank
`timescale 1ns/10ps
module pmc_mode_control_bench;
  import pmc_pkg::*;
  typedef struct {logic [9:0] num; logic [31:0] data;} pmc_row_s;
  logic sys_clk, nrst, spr_wr, spr_rd, problem_state_bit, monitor_mark_bit;
  logic instr_address_breakpoint, spr_priv_fault, monitor_irq;
  logic [9:0] spr_num;
  logic [31:0] spr_wdata, spr_rdata, got;
  logic [7:0] counter_sign, counter_update_en, counter_history_mode;
  logic [6:0] sel1;
  logic [5:0] sel2;
  logic [4:0] sel3, sel4, sel5, sel6, sel7;
  logic [3:0] sel8;
  int miscompares = 0;
  int comparisons = 0;
  // Freeze and enable bits stay clear in the first-control rows; two second-control rows set freeze bit 29
  pmc_row_s rows [6] = '{'{SPR_CTRL_SECOND, 32'hFFFF_FFFF}, '{SPR_CTRL_SECOND, 32'hA5A5_A5A5},
    '{SPR_CTRL_SECOND, 32'h5A5A_5A5A}, '{SPR_CTRL_SECOND, 32'h0000_0000},
    '{SPR_CTRL_FIRST, 32'hFFF8_0000}, '{SPR_CTRL_FIRST, 32'h5550_0000}};
  pmc_mode_control DUT (.sys_clk(sys_clk), .nrst(nrst), .spr_wr(spr_wr), .spr_rd(spr_rd),
    .spr_num(spr_num), .spr_wdata(spr_wdata), .spr_rdata(spr_rdata),
    .spr_priv_fault(spr_priv_fault), .problem_state_bit(problem_state_bit),
    .monitor_mark_bit(monitor_mark_bit), .instr_address_breakpoint(instr_address_breakpoint),
    .counter_sign(counter_sign), .counter_update_en(counter_update_en),
    .counter_history_mode(counter_history_mode), .counter_one_event_select(sel1),
    .counter_two_event_select(sel2), .counter_three_event_select(sel3),
    .counter_four_event_select(sel4), .counter_five_event_select(sel5),
    .counter_six_event_select(sel6), .counter_seven_event_select(sel7),
    .counter_eight_event_select(sel8), .monitor_irq(monitor_irq));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Strobes are lowered at the taking edge; sampling 1 ns later sees the registered answer
  task automatic spr_access(input logic wr, input logic [9:0] num, input logic [31:0] d);
    @(posedge sys_clk);
    spr_wr <= wr;
    spr_rd <= ~wr;
    spr_num <= num;
    spr_wdata <= d;
    @(posedge sys_clk);
    spr_wr <= 1'b0;
    spr_rd <= 1'b0;
    #1;
    got = spr_rdata;
  endtask
  task automatic rd_chk(input logic [9:0] num, input logic [31:0] exp);
    spr_access(1'b0, num, 32'h0000_0000);
    chk("read data", exp, got);
  endtask
  task automatic irq_case(input logic [31:0] ctrl, input logic [7:0] sgn, input logic exp);
    counter_sign <= 8'h00;
    spr_access(1'b1, SPR_CTRL_FIRST, ctrl);
    @(posedge sys_clk);
    counter_sign <= sgn;
    #1;
    chk("irq", {31'h0, exp}, {31'h0, monitor_irq});
    counter_sign <= 8'h00;
  endtask
  task automatic bkpt_pulse();
    @(posedge sys_clk);
    instr_address_breakpoint <= 1'b1;
    @(posedge sys_clk);
    instr_address_breakpoint <= 1'b0;
  endtask
  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    {nrst, spr_wr, spr_rd, problem_state_bit, monitor_mark_bit} = 5'h00;
    {instr_address_breakpoint, spr_num, spr_wdata, counter_sign} = '0;
    repeat (6) @(posedge sys_clk);
    chk("reset rdata irq", 32'h0000_0000, {spr_rdata[30:0], monitor_irq});
    nrst <= 1'b1;
    rd_chk(SPR_CTRL_SECOND, CTRL_RESET);
    rd_chk(SPR_CTRL_FIRST, CTRL_RESET);
    $display("test reset done");
    foreach (rows[i]) begin
      spr_access(1'b1, rows[i].num, rows[i].data);
      rd_chk(rows[i].num, rows[i].data);
      rd_chk(rows[i].num, rows[i].data);
      if (rows[i].num == SPR_CTRL_SECOND) begin
        chk("sel3 to 8", {3'h0, rows[i].data[28:0]}, {3'h0, sel8, sel7, sel6, sel5, sel4, sel3});
        chk("history", {24'h0, {7{rows[i].data[31]}}, rows[i].data[30]}, {24'h0, counter_history_mode});
      end else begin
        chk("sel1 sel2", {19'h0, rows[i].data[31:19]}, {19'h0, sel2, sel1});
      end
    end
    rd_chk(10'h001, 32'h0000_0000);
    $display("test table done");
    // User mode refusal: fault pulse, zero data, register untouched
    problem_state_bit <= 1'b1;
    spr_access(1'b1, SPR_CTRL_SECOND, 32'h1234_5678);
    chk("fault", 32'h1, {31'h0, spr_priv_fault});
    rd_chk(SPR_CTRL_SECOND, 32'h0000_0000);
    problem_state_bit <= 1'b0;
    rd_chk(SPR_CTRL_SECOND, 32'h0000_0000);
    $display("test privilege done");
    spr_access(1'b1, SPR_CTRL_FIRST, 32'h0000_0000);
    spr_access(1'b1, SPR_CTRL_SECOND, 32'h2000_0000);
    chk("frozen", 32'h0, {24'h0, counter_update_en});
    // A match while frozen by the freeze-all bit is not monitored
    spr_access(1'b1, SPR_CTRL_FIRST, 32'h0000_0001);
    bkpt_pulse();
    rd_chk(SPR_CTRL_SECOND, 32'h2000_0000);
    spr_access(1'b1, SPR_CTRL_FIRST, 32'h0000_0000);
    bkpt_pulse();
    rd_chk(SPR_CTRL_SECOND, 32'h0000_0000);
    chk("released", 32'hFF, {24'h0, counter_update_en});
    $display("test breakpoint freeze done");
    spr_access(1'b1, SPR_CTRL_FIRST, 32'h0004_0000);
    chk("trigger hold", 32'h01, {24'h0, counter_update_en});
    counter_sign <= 8'h01;
    repeat (2) @(posedge sys_clk);
    counter_sign <= 8'h00;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("trigger go", 32'hFF, {24'h0, counter_update_en});
    $display("test trigger done");
    irq_case(32'h0001_0020, 8'h01, 1'b1);
    irq_case(32'h0001_0000, 8'h01, 1'b0);
    irq_case(32'h0002_0020, 8'h02, 1'b1);
    irq_case(32'h0002_0020, 8'h01, 1'b0);
    $display("test interrupt done");
    // Counter one negative across an edge with freeze-on-exception set
    spr_access(1'b1, SPR_CTRL_FIRST, 32'h0001_0060);
    counter_sign <= 8'h01;
    @(posedge sys_clk);
    counter_sign <= 8'h00;
    @(posedge sys_clk);
    #1;
    chk("exc freeze", 32'h0, {24'h0, counter_update_en});
    rd_chk(SPR_CTRL_FIRST, 32'h0001_0040);
    // Other-counter enable overrides the freeze
    spr_access(1'b1, SPR_CTRL_FIRST, 32'h0003_0060);
    counter_sign <= 8'h01;
    @(posedge sys_clk);
    counter_sign <= 8'h00;
    @(posedge sys_clk);
    #1;
    chk("override", 32'hFF, {24'h0, counter_update_en});
    $display("test exception freeze done");
    // Reset in mid-run clears the second control again
    spr_access(1'b1, SPR_CTRL_SECOND, 32'hC000_0001);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    rd_chk(SPR_CTRL_SECOND, CTRL_RESET);
    chk("history after reset", 32'h0, {24'h0, counter_history_mode});
    $display("test second reset done");
    finish_test();
  end
endmodule

/* pmc_pkg.sv */
// Package for the performance monitor mode control bank
package pmc_pkg;
  localparam int unsigned WORD_W = 32;
  localparam logic [9:0] SPR_CTRL_FIRST = 10'h3B8;
  localparam logic [9:0] SPR_CTRL_SECOND = 10'h31E;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Bit positions are little-endian (bit 0 = LSB) and mirror the printed bit numbers
  localparam int unsigned B_FREEZE_ALL = 0;
  localparam int unsigned B_FREEZE_SUP = 1;
  localparam int unsigned B_FREEZE_USR = 2;
  localparam int unsigned B_FREEZE_MARK1 = 3;
  localparam int unsigned B_FREEZE_MARK0 = 4;
  localparam int unsigned B_GLOBAL_XE = 5;
  localparam int unsigned B_FREEZE_EXC = 6;
  localparam int unsigned B_FIRST_XE = 16;
  localparam int unsigned B_OTHER_XE = 17;
  localparam int unsigned B_TRIGGER = 18;
  localparam int unsigned F_SEL1_LO = 19;
  localparam int unsigned F_SEL2_LO = 26;
  localparam int unsigned F_SEL3_LO = 0;
  localparam int unsigned F_SEL4_LO = 5;
  localparam int unsigned F_SEL5_LO = 10;
  localparam int unsigned F_SEL6_LO = 15;
  localparam int unsigned F_SEL7_LO = 20;
  localparam int unsigned F_SEL8_LO = 25;
  localparam int unsigned B_FREEZE_BKPT = 29;
  localparam int unsigned B_HIST_FIRST = 30;
  localparam int unsigned B_HIST_OTHER = 31;
  localparam int unsigned SEL1_W = 7;
  localparam int unsigned SEL2_W = 6;
  localparam int unsigned SEL_MID_W = 5;
  localparam int unsigned SEL8_W = 4;
  localparam int unsigned NUM_COUNTERS = 8;
endpackage
